/* File: bench/bsifc_bus_model.sv */
`timescale 1ns/1ps
module bsifc_bus_model (
    // Device side
    input wire logic up_pd,
    input wire logic dn_pd,
    input wire logic sw,
    // Injected shorts to supply
    input wire logic up_short,
    input wire logic dn_short,
    // Comparator levels
    output logic up_high,
    output logic dn_high
);
    // A short beats the sink; downstream is only powered through a closed switch
    assign up_high = up_short || !up_pd;
    assign dn_high = dn_short || (sw && !dn_pd);
endmodule

/* File: bench/bsifc_top_chk.sv */
`timescale 1ns/1ps
`include "bsifc_params.svh"
module bsifc_chk (
    // Clock, reset and commands
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic INIT_CMD,
    input wire logic REV_INIT_CMD,
    input wire logic [3:0] CMD_ADDR,
    input wire logic [3:0] CMD_PROG_ADDR,
    input wire logic CMD_SWITCH_CLOSE_REQUEST,
    input wire logic LOOPBACK_ACTIVE,
    // Device outputs
    input wire logic SWITCH_CLOSED,
    input wire logic UPSTREAM_PULLDOWN_EN,
    input wire logic DOWNSTREAM_PULLDOWN_EN,
    input wire logic [3:0] DEV_ADDR,
    input wire logic NONVOLATILE_WRITE_PERMIT,
    input wire logic FAULT_SEEN_FLAG,
    input wire logic INITIALIZED,
    input wire logic TEST_BUSY,
    input wire logic ACCEPTED
);
    logic take;
    logic pd;
    logic [14:0] cnt_r;
    logic [14:0] cnt_nxt;
    assign take = (INIT_CMD || REV_INIT_CMD) && !INITIALIZED && !TEST_BUSY;
    assign pd = UPSTREAM_PULLDOWN_EN || DOWNSTREAM_PULLDOWN_EN;
    // Length of the current sink window
    always_comb cnt_nxt = (RST_N && pd) ? cnt_r + 15'h0001 : 15'h0000;
    always_ff @(posedge CLK) cnt_r <= cnt_nxt;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_result;
        ##[1:3] (SWITCH_CLOSED ^ FAULT_SEEN_FLAG);
    endsequence
    chk_accept_cause: assert property (ACCEPTED |-> $past(take))
        else $error("accept without a takeable init");
    chk_refuse_reinit: assert property ((INIT_CMD || REV_INIT_CMD) && INITIALIZED |=> !ACCEPTED)
        else $error("re-init was accepted");
    chk_fwd_side: assert property (take && INIT_CMD && CMD_ADDR != 4'h0 && CMD_SWITCH_CLOSE_REQUEST
        && !LOOPBACK_ACTIVE |=> DOWNSTREAM_PULLDOWN_EN && !UPSTREAM_PULLDOWN_EN)
        else $error("forward test on wrong side");
    chk_rev_side: assert property (take && !INIT_CMD && CMD_ADDR != 4'h0 && CMD_SWITCH_CLOSE_REQUEST
        && !LOOPBACK_ACTIVE |=> UPSTREAM_PULLDOWN_EN && !DOWNSTREAM_PULLDOWN_EN)
        else $error("reverse test on wrong side");
    chk_test_len: assert property ($fell(pd) && $past(RST_N) |-> cnt_r == `BSIFC_FAULT_TEST_CYC)
        else $error("fault test length wrong");
    chk_test_result: assert property ($fell(TEST_BUSY) && $past(RST_N) |-> s_result)
        else $error("switch does not follow test result");
    chk_fault_open: assert property (FAULT_SEEN_FLAG |-> !SWITCH_CLOSED)
        else $error("switch closed despite fault");
    chk_glob_open: assert property (take && CMD_ADDR == 4'h0 |=> DEV_ADDR == 4'h0
        && !SWITCH_CLOSED && !NONVOLATILE_WRITE_PERMIT && !TEST_BUSY)
        else $error("global init misbehaved");
    chk_loop_close: assert property (take && CMD_ADDR != 4'h0 && CMD_SWITCH_CLOSE_REQUEST
        && LOOPBACK_ACTIVE |=> !TEST_BUSY ##[0:1] SWITCH_CLOSED)
        else $error("loop-back init ran a test");
    chk_addr_store: assert property (take && CMD_ADDR != 4'h0 |=> DEV_ADDR == $past(CMD_PROG_ADDR))
        else $error("programmed address not stored");
endmodule
bind bsifc_top bsifc_chk u_chk (.*);

/* File: bench/bsifc_top_tb.sv */
`timescale 1ns/1ps
`include "bsifc_params.svh"
`define CHK(n, e, a) checks_done++; if ((a) !== (e)) begin failures++; $display("mismatch %s exp %0h got %0h", n, e, a); end
module bsifc_top_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] stb = 4'h0;
    logic frm = 1'b0;
    logic [3:0] ca = 4'h0;
    logic [3:0] pa = 4'h0;
    logic cl = 1'b0;
    logic nv = 1'b0;
    logic lp = 1'b0;
    logic us = 1'b0;
    logic ds = 1'b0;
    logic uh, dh, sw, upd, dpd, nvo, flt, ini, bsy, rep, acc;
    logic [3:0] da;
    logic [1:0] dg;
    int failures = 0;
    int checks_done = 0;
    bsifc_top dut (.CLK(clk), .RST_N(rst_n), .INIT_CMD(stb[0]), .REV_INIT_CMD(stb[1]),
        .CLEAR_CMD(stb[2]), .OTHER_CMD(stb[3]), .FRAME_START(frm), .CMD_ADDR(ca),
        .CMD_PROG_ADDR(pa), .CMD_GROUP(2'h2), .CMD_SWITCH_CLOSE_REQUEST(cl),
        .CMD_NONVOLATILE_WRITE_PERMIT(nv), .UPSTREAM_BUS_PIN_HIGH(uh),
        .DOWNSTREAM_BUS_PIN_HIGH(dh), .LOOPBACK_ACTIVE(lp), .SWITCH_CLOSED(sw),
        .UPSTREAM_PULLDOWN_EN(upd), .DOWNSTREAM_PULLDOWN_EN(dpd), .DEV_ADDR(da),
        .DEV_GROUP(dg), .NONVOLATILE_WRITE_PERMIT(nvo), .FAULT_SEEN_FLAG(flt),
        .INITIALIZED(ini), .TEST_BUSY(bsy), .REPLY_ENABLE(rep), .ACCEPTED(acc));
    bsifc_bus_model bus (.up_pd(upd), .dn_pd(dpd), .sw(sw), .up_short(us),
        .dn_short(ds), .up_high(uh), .dn_high(dh));
    task automatic wrap_up();
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Strobe bits: init, reverse init, clear, other
    task automatic cmd(input logic [3:0] k, input logic [3:0] a, input logic [3:0] p,
        input logic c, input logic n);
        @(posedge clk);
        stb <= k;
        ca <= a;
        pa <= p;
        cl <= c;
        nv <= n;
        @(posedge clk);
        stb <= 4'h0;
        #1;
    endtask
    task automatic frame();
        @(posedge clk);
        frm <= 1'b1;
        @(posedge clk);
        frm <= 1'b0;
        #1;
    endtask
    task automatic wait_test();
        int i;
        for (i = 0; i < 25000 && bsy === 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 25000) begin
            failures++;
            wrap_up();
        end
        // Settle time so downstream can power before the next init
        repeat (4) @(posedge clk);
        #1;
    endtask
    initial forever #5 clk = ~clk;
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        cmd(4'h1, 4'h5, 4'h5, 1'b1, 1'b0);
        `CHK("accepted", 1'b1, acc)
        `CHK("dn_pulldown", 1'b1, dpd)
        `CHK("up_pulldown", 1'b0, upd)
        `CHK("addr", 4'h5, da)
        `CHK("group", 2'h2, dg)
        cmd(4'h1, 4'h7, 4'h7, 1'b1, 1'b0);
        `CHK("accepted", 1'b0, acc)
        wait_test();
        `CHK("fault", 1'b0, flt)
        `CHK("switch", 1'b1, sw)
        frame();
        `CHK("reply", 1'b1, rep)
        cmd(4'h4, 4'h0, 4'h0, 1'b0, 1'b0);
        us <= 1'b1;
        cmd(4'h2, 4'h3, 4'h9, 1'b1, 1'b0);
        `CHK("up_pulldown", 1'b1, upd)
        `CHK("addr", 4'h9, da)
        wait_test();
        `CHK("fault", 1'b1, flt)
        `CHK("switch", 1'b0, sw)
        us <= 1'b0;
        cmd(4'h4, 4'h0, 4'h0, 1'b0, 1'b0);
        ds <= 1'b1;
        cmd(4'h1, 4'h4, 4'h4, 1'b1, 1'b0);
        `CHK("dn_pulldown", 1'b1, dpd)
        wait_test();
        `CHK("fault", 1'b1, flt)
        `CHK("switch", 1'b0, sw)
        ds <= 1'b0;
        cmd(4'h4, 4'h0, 4'h0, 1'b0, 1'b0);
        lp <= 1'b1;
        cmd(4'h1, 4'h6, 4'h6, 1'b1, 1'b0);
        `CHK("busy", 1'b0, bsy)
        @(posedge clk);
        #1;
        `CHK("switch", 1'b1, sw)
        lp <= 1'b0;
        cmd(4'h4, 4'h0, 4'h0, 1'b0, 1'b0);
        cmd(4'h1, 4'h0, 4'hA, 1'b1, 1'b1);
        `CHK("addr", 4'h0, da)
        `CHK("busy", 1'b0, bsy)
        repeat (3) @(posedge clk);
        #1;
        `CHK("switch", 1'b0, sw)
        `CHK("permit", 1'b0, nvo)
        cmd(4'h2, 4'h5, 4'h5, 1'b1, 1'b0);
        `CHK("accepted", 1'b0, acc)
        cmd(4'h8, 4'h0, 4'h0, 1'b0, 1'b0);
        frame();
        `CHK("reply", 1'b0, rep)
        wrap_up();
    end
endmodule

/* File: verilog/bsifc_fault_timer.sv */
`timescale 1ns/1ps
`include "bsifc_params.svh"

// Times the fault test window and latches any high level seen on the tested side
module bsifc_fault_timer (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Control
    input wire logic start,
    input wire logic side_high,
    // Result
    output logic done,
    output logic fault
);
    logic [`BSIFC_CNT_W-1:0] cnt_r;
    logic [`BSIFC_CNT_W-1:0] cnt_nxt;
    logic run_r;
    logic run_nxt;
    logic fault_r;
    logic fault_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        fault_nxt = fault_r;
        if (start) begin
            cnt_nxt = `BSIFC_CNT_W'(`BSIFC_FAULT_TEST_CYC - 1);
            run_nxt = 1'b1;
            fault_nxt = 1'b0;
        end else if (run_r) begin
            // Level sampled over the whole window so a brief short still counts
            if (side_high) begin
                fault_nxt = 1'b1;
            end
            if (cnt_r == '0) begin
                run_nxt = 1'b0;
            end else begin
                cnt_nxt = cnt_r - `BSIFC_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cnt_r <= '0;
            run_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            fault_r <= fault_nxt;
        end
    end

    // Done in the last window cycle keeps the sink on for exactly the counted cycles
    assign done = run_r && (cnt_r == '0);
    // The last cycle's sample is folded in so it is not lost at the hand-over
    assign fault = fault_r || (run_r && side_high);
endmodule

/* File: verilog/bsifc_params.svh */
`ifndef BSIFC_PARAMS_SVH
`define BSIFC_PARAMS_SVH

// Fault test length in microseconds and in 100 MHz cycles
`define BSIFC_CLK_MHZ 100
`define BSIFC_FAULT_TEST_US 200
`define BSIFC_FAULT_TEST_CYC (`BSIFC_FAULT_TEST_US * `BSIFC_CLK_MHZ)
`define BSIFC_CNT_W 15
`define BSIFC_GLOBAL_ADDR 4'h0
`define BSIFC_ADDR_RST 4'h0
`define BSIFC_GROUP_RST 2'h0

`endif

/* File: verilog/bsifc_pkg.sv */
package bsifc_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_TEST  = 5'h02,
        ST_CLOSE = 5'h04,
        ST_OPEN  = 5'h08,
        ST_GLOB  = 5'h10
    } bsifc_state_e;
    typedef logic [3:0] bsifc_addr_t;
endpackage

/* File: verilog/bsifc_top.sv */
`timescale 1ns/1ps
`include "bsifc_params.svh"

// What this block does
// - Inactive side above 3V means bus fault
// - Forward tests downstream pin, reverse tests upstream
// - One fault test per init, 11 mA pull-down
// - Fault test lasts 200 us, host waits
// - Switch closes only when no fault found
// - Same test for programmed and unprogrammed parts
// - Loop-back, both sides active: skip test
// - Global address init sets address zero
// - Global init keeps switch open
// - Global init ignores write-permit and close bits
// - At address zero execute, never reply
// - After global init, reject re-init until clear
// - Reply goes out with the next command
// - Initialized device ignores init until clear/reset
// - Normal init stores address, group, maybe closes
module bsifc_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Decoded command strobes, one cycle each
    input wire logic INIT_CMD,
    input wire logic REV_INIT_CMD,
    input wire logic CLEAR_CMD,
    input wire logic OTHER_CMD,
    input wire logic FRAME_START,
    // Command fields
    input wire logic [3:0] CMD_ADDR,
    input wire logic [3:0] CMD_PROG_ADDR,
    input wire logic [1:0] CMD_GROUP,
    input wire logic CMD_SWITCH_CLOSE_REQUEST,
    input wire logic CMD_NONVOLATILE_WRITE_PERMIT,
    // Analog comparators and topology
    input wire logic UPSTREAM_BUS_PIN_HIGH,
    input wire logic DOWNSTREAM_BUS_PIN_HIGH,
    input wire logic LOOPBACK_ACTIVE,
    // Bus side controls
    output logic SWITCH_CLOSED,
    output logic UPSTREAM_PULLDOWN_EN,
    output logic DOWNSTREAM_PULLDOWN_EN,
    // Device state
    output logic [3:0] DEV_ADDR,
    output logic [1:0] DEV_GROUP,
    output logic NONVOLATILE_WRITE_PERMIT,
    output logic FAULT_SEEN_FLAG,
    output logic INITIALIZED,
    output logic TEST_BUSY,
    // Reply gating for the frame in progress, and the init accept strobe
    output logic REPLY_ENABLE,
    output logic ACCEPTED
);
    bsifc_pkg::bsifc_state_e state_r;
    bsifc_pkg::bsifc_state_e state_nxt;
    bsifc_pkg::bsifc_addr_t addr_r;
    bsifc_pkg::bsifc_addr_t addr_nxt;
    logic [1:0] group_r;
    logic [1:0] group_nxt;
    logic nv_r;
    logic nv_nxt;
    logic sw_r;
    logic sw_nxt;
    logic bf_r;
    logic bf_nxt;
    logic init_r;
    logic init_nxt;
    logic rev_r;
    logic rev_nxt;
    logic pend_r;
    logic pend_nxt;
    logic reply_r;
    logic reply_nxt;
    logic acc_r;
    logic acc_nxt;
    logic any_init;
    logic test_start;
    logic test_done;
    logic test_fault;
    logic side_high;

    assign any_init = INIT_CMD | REV_INIT_CMD;
    // Reverse init tests the upstream pin, forward the downstream one
    assign side_high = rev_r ? UPSTREAM_BUS_PIN_HIGH : DOWNSTREAM_BUS_PIN_HIGH;

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        group_nxt = group_r;
        nv_nxt = nv_r;
        sw_nxt = sw_r;
        bf_nxt = bf_r;
        init_nxt = init_r;
        rev_nxt = rev_r;
        pend_nxt = pend_r;
        reply_nxt = reply_r;
        acc_nxt = 1'b0;
        test_start = 1'b0;
        // The reply to a command is owed at the next frame start
        if (FRAME_START) begin
            reply_nxt = pend_r;
            pend_nxt = 1'b0;
        end
        case (state_r)
            bsifc_pkg::ST_IDLE: begin
                if (CLEAR_CMD) begin
                    init_nxt = 1'b0;
                    sw_nxt = 1'b0;
                    bf_nxt = 1'b0;
                    nv_nxt = 1'b0;
                end else if (any_init && !init_r) begin
                    acc_nxt = 1'b1;
                    init_nxt = 1'b1;
                    rev_nxt = REV_INIT_CMD;
                    pend_nxt = (CMD_ADDR != `BSIFC_GLOBAL_ADDR);
                    if (CMD_ADDR == `BSIFC_GLOBAL_ADDR) begin
                        addr_nxt = `BSIFC_GLOBAL_ADDR;
                        sw_nxt = 1'b0;
                        state_nxt = bsifc_pkg::ST_IDLE;
                    end else begin
                        addr_nxt = CMD_PROG_ADDR;
                        group_nxt = CMD_GROUP;
                        nv_nxt = CMD_NONVOLATILE_WRITE_PERMIT;
                        if (CMD_SWITCH_CLOSE_REQUEST && !LOOPBACK_ACTIVE) begin
                            test_start = 1'b1;
                            bf_nxt = 1'b0;
                            state_nxt = bsifc_pkg::ST_TEST;
                        end else if (CMD_SWITCH_CLOSE_REQUEST) begin
                            sw_nxt = 1'b1;
                        end
                    end
                end else if (OTHER_CMD && addr_r != `BSIFC_GLOBAL_ADDR) begin
                    pend_nxt = 1'b1;
                end
            end
            bsifc_pkg::ST_TEST: begin
                // Further init commands ignored here since this state decodes no commands
                if (test_done) begin
                    bf_nxt = test_fault;
                    state_nxt = test_fault ? bsifc_pkg::ST_OPEN : bsifc_pkg::ST_CLOSE;
                end
            end
            bsifc_pkg::ST_CLOSE: begin
                sw_nxt = 1'b1;
                state_nxt = bsifc_pkg::ST_IDLE;
            end
            bsifc_pkg::ST_OPEN: begin
                sw_nxt = 1'b0;
                state_nxt = bsifc_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = bsifc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_r <= bsifc_pkg::ST_IDLE;
            addr_r <= `BSIFC_ADDR_RST;
            group_r <= `BSIFC_GROUP_RST;
            nv_r <= 1'b0;
            sw_r <= 1'b0;
            bf_r <= 1'b0;
            init_r <= 1'b0;
            rev_r <= 1'b0;
            pend_r <= 1'b0;
            reply_r <= 1'b0;
            acc_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            group_r <= group_nxt;
            nv_r <= nv_nxt;
            sw_r <= sw_nxt;
            bf_r <= bf_nxt;
            init_r <= init_nxt;
            rev_r <= rev_nxt;
            pend_r <= pend_nxt;
            reply_r <= reply_nxt;
            acc_r <= acc_nxt;
        end
    end

    bsifc_fault_timer u_timer (
        .CLK(CLK),
        .RST_N(RST_N),
        .start(test_start),
        .side_high(side_high),
        .done(test_done),
        .fault(test_fault)
    );

    // Pull-down sinks current only on the side under test
    assign UPSTREAM_PULLDOWN_EN = (state_r == bsifc_pkg::ST_TEST) && rev_r;
    assign DOWNSTREAM_PULLDOWN_EN = (state_r == bsifc_pkg::ST_TEST) && !rev_r;
    assign TEST_BUSY = (state_r == bsifc_pkg::ST_TEST);
    assign SWITCH_CLOSED = sw_r;
    assign DEV_ADDR = addr_r;
    assign DEV_GROUP = group_r;
    assign NONVOLATILE_WRITE_PERMIT = nv_r;
    assign FAULT_SEEN_FLAG = bf_r;
    assign INITIALIZED = init_r;
    assign REPLY_ENABLE = reply_r;
    assign ACCEPTED = acc_r;
endmodule
